// file: inc/sync_consts.svh
`ifndef SYNC_CONSTS_SVH
`define SYNC_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define REG_SYNC_SEL      8'h0e
`define REG_HOLD_SEL      8'h0f
`define REG_VS_THRESH     8'h11

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define BIT_HS_SRC        3
`define BIT_VS_SRC        0
`define BIT_HOLD_SRC      5

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_SYNC_SEL      8'h00
`define RST_HOLD_SEL      8'h00
`define RST_VS_THRESH     8'h20

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SYS_CLK_HZ        40000000
`define SEP_CLK_HZ        5000000
`define SEP_DIV           (`SYS_CLK_HZ / `SEP_CLK_HZ)

`endif

// file: inc/sync_pkg.sv
package sync_pkg;
  // Separator phases, one-hot
  typedef enum logic [1:0] {
    SEEK_VSYNC = 2'b01,
    WAIT_END   = 2'b10
  } sep_state_t;
endpackage

// file: inc/sep_if.sv
`timescale 1ns/1ps
interface sep_if #(parameter int CW = 8);
  logic          tick;
  logic          csync;
  logic [CW-1:0] thresh;
  logic          vsync_sep;
  logic [CW-1:0] count;
  logic          present;

  modport ctl (output tick, output csync, output thresh,
               input vsync_sep, input count, input present);
  modport sep (input tick, input csync, input thresh,
               output vsync_sep, output count, output present);
endinterface

// file: rtl/vsync_separator.sv
`timescale 1ns/1ps
`include "sync_consts.svh"
module vsync_separator
  import sync_pkg::*;
#(
  parameter int CW = 8
) (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic reset_n,
  // Control side
  sep_if.sep        sif
);

  localparam logic [CW-1:0] CNT_MAX  = {CW{1'b1}};
  localparam logic [CW-1:0] CNT_ZERO = '0;

  sep_state_t    state_r;
  sep_state_t    state_nxt;
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;

  // ----------------------------------------------------------------
  // Counter decode
  // ----------------------------------------------------------------
  wire logic          at_max  = (cnt_r == CNT_MAX);
  wire logic          at_zero = (cnt_r == CNT_ZERO);
  wire logic [CW-1:0] cnt_up  = at_max ? cnt_r : cnt_r + 1'b1;
  wire logic [CW-1:0] cnt_dn  = at_zero ? cnt_r : cnt_r - 1'b1;
  wire logic          over_th = (cnt_r > sif.thresh);
  wire logic          gap_th  = (cnt_r >= sif.thresh);

  // Next state; only 5 MHz ticks move anything
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    if (sif.tick) begin
      unique case (state_r)
        SEEK_VSYNC: begin
          if (over_th) begin
            state_nxt = WAIT_END;
            cnt_nxt   = CNT_ZERO;
          end else begin
            cnt_nxt = sif.csync ? cnt_up : cnt_dn;
          end
        end
        WAIT_END: begin
          if (gap_th) begin
            state_nxt = SEEK_VSYNC;
            cnt_nxt   = CNT_ZERO;
          end else begin
            // Serration pulse restarts the gap measurement
            cnt_nxt = sif.csync ? CNT_ZERO : cnt_up;
          end
        end
      endcase
    end
  end

  // State and counter
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= SEEK_VSYNC;
      cnt_r   <= CNT_ZERO;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  assign sif.vsync_sep = (state_r == WAIT_END);
  assign sif.present   = (state_r == WAIT_END);
  assign sif.count     = cnt_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_cnt_no_wrap: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    $past(cnt_r) == CNT_MAX && $past(state_r) == SEEK_VSYNC
      && !$past(over_th) |-> cnt_r != CNT_ZERO)
    else $error("counter wrapped past maximum");

  chk_count_up: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    sif.tick && state_r == SEEK_VSYNC && sif.csync && !over_th
      && !at_max |=> cnt_r == $past(cnt_r) + 1'b1)
    else $error("counter did not rise during pulse");

  chk_count_down: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    sif.tick && state_r == SEEK_VSYNC && !sif.csync && !over_th
      |=> cnt_r == ($past(at_zero) ? CNT_ZERO : $past(cnt_r) - 1'b1))
    else $error("counter did not decay to floor");

  chk_no_tick_hold: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    !sif.tick |=> $stable(cnt_r) && $stable(state_r))
    else $error("counter moved without a tick");

  chk_detect_clear: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    sif.tick && state_r == SEEK_VSYNC && cnt_r > sif.thresh
      |=> sif.present && cnt_r == CNT_ZERO)
    else $error("vsync not declared above threshold");

  chk_release_rearm: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    sif.tick && state_r == WAIT_END && cnt_r >= sif.thresh
      |=> !sif.present && cnt_r == CNT_ZERO)
    else $error("vsync not released at threshold");

endmodule

// file: rtl/composite_sync_separator.sv
`timescale 1ns/1ps
`include "sync_consts.svh"
module composite_sync_separator
  import sync_pkg::*;
#(
  parameter int CW = 8
) (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       reset_n,
  // Sync pins and sources
  input  wire logic       hsync_in,
  input  wire logic       green_channel_sync,
  input  wire logic       vsync_in,
  input  wire logic       hold_in,
  input  wire logic       csync_active_low,
  // Register port from serial control
  input  wire logic       reg_wr_en,
  input  wire logic       reg_rd_en,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  // Routed sync outputs
  output logic            hsync_out,
  output logic            hold_out,
  output logic            vsync_out,
  output logic            vsync_present
);

  localparam int DIV = `SEP_DIV;
  localparam int DW  = $clog2(DIV);
  localparam logic [DW-1:0] DIV_LAST = DW'(DIV - 1);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  localparam int NIN = 5;
  wire logic [NIN-1:0] pin_raw = {csync_active_low, hold_in, vsync_in,
                                  green_channel_sync, hsync_in};
  logic [NIN-1:0] pin_s1_r;
  logic [NIN-1:0] pin_s2_r;

  // Two flops per pin; first stage feeds only the second
  genvar gi;
  generate
    for (gi = 0; gi < NIN; gi++) begin : g_sync
      always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          pin_s1_r[gi] <= 1'b0;
          pin_s2_r[gi] <= 1'b0;
        end else begin
          pin_s1_r[gi] <= pin_raw[gi];
          pin_s2_r[gi] <= pin_s1_r[gi];
        end
      end
    end
  endgenerate

  wire logic hs_s  = pin_s2_r[0];
  wire logic grn_s = pin_s2_r[1];
  wire logic vs_s  = pin_s2_r[2];
  wire logic hld_s = pin_s2_r[3];
  wire logic inv_s = pin_s2_r[4];

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [7:0] sync_sel_r;
  logic [7:0] hold_sel_r;
  logic [7:0] thresh_r;

  // Address decode
  wire logic hit_sync = (reg_addr == `REG_SYNC_SEL);
  wire logic hit_hold = (reg_addr == `REG_HOLD_SEL);
  wire logic hit_th   = (reg_addr == `REG_VS_THRESH);

  // Only implemented select bits are kept; the rest read as zero
  localparam logic [7:0] SYNC_MASK =
    (8'h01 << `BIT_HS_SRC) | (8'h01 << `BIT_VS_SRC);
  localparam logic [7:0] HOLD_MASK = (8'h01 << `BIT_HOLD_SRC);

  // Register writes
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sync_sel_r <= `RST_SYNC_SEL;
      hold_sel_r <= `RST_HOLD_SEL;
      thresh_r   <= `RST_VS_THRESH;
    end else if (reg_wr_en) begin
      if (hit_sync) sync_sel_r <= reg_wdata & SYNC_MASK;
      if (hit_hold) hold_sel_r <= reg_wdata & HOLD_MASK;
      if (hit_th)   thresh_r   <= reg_wdata;
    end
  end

  // Read select; unmapped addresses answer zero
  wire logic [7:0] rd_mux = hit_sync ? sync_sel_r :
                            hit_hold ? hold_sel_r :
                            hit_th   ? thresh_r   : 8'h00;

  // Registered read data
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd_en) begin
      reg_rdata <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // 5 MHz tick divider
  // ----------------------------------------------------------------
  logic [DW-1:0] div_r;
  wire logic     div_end = (div_r == DIV_LAST);

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      div_r <= '0;
    end else begin
      div_r <= div_end ? '0 : div_r + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Source selection
  // ----------------------------------------------------------------
  wire logic sel_grn  = sync_sel_r[`BIT_HS_SRC];
  wire logic sel_sep  = sync_sel_r[`BIT_VS_SRC];
  wire logic sel_vsh  = hold_sel_r[`BIT_HOLD_SRC];

  wire logic hs_mux   = sel_grn ? grn_s : hs_s;
  wire logic hold_mux = sel_vsh ? vs_s : hld_s;
  wire logic csync_n  = hs_mux ^ inv_s;

  sep_if #(.CW(CW)) sif ();

  assign sif.tick   = div_end;
  assign sif.csync  = csync_n;
  assign sif.thresh = thresh_r;

  vsync_separator #(
    .CW (CW)
  ) u_sep (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .sif     (sif)
  );

  wire logic vs_mux = sel_sep ? sif.vsync_sep : vs_s;

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  // One flop after every mux keeps outputs glitch free on reselect
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      hsync_out     <= 1'b0;
      hold_out      <= 1'b0;
      vsync_out     <= 1'b0;
      vsync_present <= 1'b0;
    end else begin
      hsync_out     <= hs_mux;
      hold_out      <= hold_mux;
      vsync_out     <= vs_mux;
      vsync_present <= sif.present;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_hsync_route: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    ##1 hsync_out == ($past(sel_grn) ? $past(grn_s) : $past(hs_s)))
    else $error("horizontal sync routed from wrong source");

  chk_hold_route: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    ##1 hold_out == ($past(sel_vsh) ? $past(vs_s) : $past(hld_s)))
    else $error("hold path routed from wrong source");

  chk_vsync_route: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    ##1 vsync_out == ($past(sel_sep) ? $past(sif.vsync_sep)
                                     : $past(vs_s)))
    else $error("vertical sync routed from wrong source");

  chk_tick_period: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    sif.tick |=> !sif.tick [*7] ##1 sif.tick)
    else $error("separator tick not every eight clocks");

  chk_polarity_norm: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    ##1 $past(sif.csync) == (hsync_out ^ $past(inv_s)))
    else $error("composite sync not normalised");

  chk_thresh_write: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    reg_wr_en && hit_th |=> thresh_r == $past(reg_wdata))
    else $error("threshold register did not take write");

  chk_present_out: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    ##1 vsync_present == $past(sif.present))
    else $error("presence output does not follow separator");

  chk_sel_masked: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (sync_sel_r & ~SYNC_MASK) == 8'h00
      && (hold_sel_r & ~HOLD_MASK) == 8'h00)
    else $error("unimplemented select bits were kept");

endmodule

// file: bench/csync_source.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Composite sync source, lengths counted in clocks
// ------------------------------------------------------------
module csync_source (
  // Clock
  input  wire logic        sys_clk,
  // Control
  input  wire logic        run,
  input  wire logic        active_low,
  input  wire logic [11:0] hi_len,
  input  wire logic [11:0] lo_len,
  // Sync pin
  output logic             csync
);
  logic [11:0] cnt_r;
  logic        act_r;
  logic        wrap;

  // End of one pulse-plus-gap period
  assign wrap = (cnt_r == hi_len + lo_len - 12'h001);

  // Pulse then gap; idles inactive between bursts, like a real source
  always_ff @(posedge sys_clk) begin
    if (!run) begin
      cnt_r <= 12'h000;
      act_r <= 1'b0;
    end else begin
      act_r <= (cnt_r < hi_len);
      cnt_r <= wrap ? 12'h000 : cnt_r + 12'h001;
    end
  end

  // Polarity applied only at the pin
  assign csync = act_r ^ active_low;
endmodule

// file: bench/testbench.sv
`timescale 1ns/1ps
module testbench;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic        sys_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        hs_r = 1'b0, green_r = 1'b0, vs_r = 1'b0, hold_r = 1'b0;
  logic        pol_r = 1'b0, run_r = 1'b0, use_src = 1'b0, probe = 1'b0;
  logic        wr_en = 1'b0, rd_en = 1'b0, rd_d1 = 1'b0;
  logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata;
  logic [11:0] hi_len = 12'h000, lo_len = 12'h000;
  logic        src_cs, hsync_in, hsync_out, hold_out, vsync_out;
  logic        vsync_present;
  logic [7:0]  exp_v;
  wire  [7:0]  seen = {4'h0, hsync_out, hold_out, vsync_out, vsync_present};
  logic [31:0] rng = 32'h0001_45fd;
  logic [7:0]  rq[$], sq[$];
  int          err_count = 0, checks_done = 0;

  // Clock and pin source select
  always #12.5 sys_clk = ~sys_clk;
  assign hsync_in = use_src ? src_cs : hs_r;

  csync_source i_src (
    .sys_clk(sys_clk), .run(run_r), .active_low(pol_r),
    .hi_len(hi_len), .lo_len(lo_len), .csync(src_cs)
  );

  composite_sync_separator #(.CW(8)) i_dut (
    .sys_clk(sys_clk), .reset_n(reset_n), .hsync_in(hsync_in),
    .green_channel_sync(green_r), .vsync_in(vs_r), .hold_in(hold_r),
    .csync_active_low(pol_r), .reg_wr_en(wr_en), .reg_rd_en(rd_en),
    .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata),
    .hsync_out(hsync_out), .hold_out(hold_out), .vsync_out(vsync_out),
    .vsync_present(vsync_present)
  );

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    $display("Checks %0d, errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    wr_en <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge sys_clk);
    wr_en <= 1'b0;
  endtask

  // Read strobe; the note is queued with the strobe and checked when the data lands
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    rd_en <= 1'b1;
    addr  <= a;
    rq.push_back(e);
    @(posedge sys_clk);
    rd_en <= 1'b0;
  endtask

  task automatic look(input logic [7:0] e);
    @(posedge sys_clk);
    probe <= 1'b1;
    sq.push_back(e);
    @(posedge sys_clk);
    probe <= 1'b0;
  endtask

  // Burst of sync, then idle; the far side holds its idle level after
  task automatic burst(input logic [11:0] h, input logic [11:0] l,
                       input logic [11:0] n, input logic p);
    @(posedge sys_clk);
    hi_len <= h;
    lo_len <= l;
    run_r  <= 1'b1;
    repeat (n) @(posedge sys_clk);
    run_r <= 1'b0;
    repeat (5) @(posedge sys_clk);
    look({4'h0, pol_r, hold_r, p, p});
    repeat (100) @(posedge sys_clk);
    if (p)
      look({4'h0, pol_r, hold_r, 2'b00});
  endtask

  // Monitor: oldest note against each result as it appears
  always @(posedge sys_clk) begin
    rd_d1 <= rd_en;
    if (rd_d1)
      check(rdata, rq.pop_front());
    if (probe)
      check(seen, sq.pop_front());
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (5) @(posedge sys_clk);
    reset_n <= 1'b1;
    // Reset values, kept bits and an unmapped place
    rd(8'h11, 8'h20);
    rd(8'h0e, 8'h00);
    rd(8'h0f, 8'h00);
    rd(8'h12, 8'h00);
    wr(8'h0e, 8'hff);
    wr(8'h0f, 8'hff);
    wr(8'h12, 8'h55);
    rd(8'h0e, 8'h09);
    rd(8'h0f, 8'h20);
    rd(8'h12, 8'h00);
    // Every select combination; polarity keeps the separator idle
    for (int i = 0; i < 8; i++) begin
      rng = xs(rng);
      wr(8'h0e, {4'h0, i[0], 2'b00, i[2]});
      wr(8'h0f, {2'b00, i[1], 5'h00});
      @(posedge sys_clk);
      {hs_r, green_r, vs_r, hold_r} <= rng[3:0];
      pol_r <= i[0] ? rng[2] : rng[3];
      repeat (5) @(posedge sys_clk);
      exp_v = {4'h0, i[0] ? green_r : hs_r, i[1] ? vs_r : hold_r,
               i[2] ? 1'b0 : vs_r, 1'b0};
      look(exp_v);
    end
    // Separator on the pin, threshold 5, both polarities
    wr(8'h0f, 8'h00);
    wr(8'h11, 8'h05);
    rd(8'h11, 8'h05);
    use_src <= 1'b1;
    wr(8'h0e, 8'h01);
    for (int k = 0; k < 2; k++) begin
      pol_r <= k[0];
      burst(12'h020, 12'h020, 12'h500, 1'b0);
      burst(12'h020, 12'h010, 12'h500, 1'b1);
      burst(12'h028, 12'h3e8, 12'h03c, 1'b0);
      burst(12'h040, 12'h3e8, 12'h046, 1'b1);
    end
    // Long pulse must stick at 255; a wrapped count misses threshold 254
    wr(8'h11, 8'hff);
    hi_len <= 12'h900;
    lo_len <= 12'h010;
    run_r  <= 1'b1;
    repeat (2200) @(posedge sys_clk);
    wr(8'h11, 8'hfe);
    repeat (20) @(posedge sys_clk);
    look({4'h0, ~pol_r, hold_r, 2'b11});
    wr(8'h11, 8'h05);
    run_r <= 1'b0;
    repeat (100) @(posedge sys_clk);
    look({4'h0, pol_r, hold_r, 2'b00});
    wrap_up();
  end

  // Watchdog, about three times the expected run
  initial begin
    #650000;
    err_count++;
    wrap_up();
  end
endmodule
